// ---- dv/ddi_src.sv ----
// Purpose: behavioural data source for one converter channel
// Assumes: runs on the core clock; one word per strobe period
// Notes:   strobe and clock are tied, so both stand low while stopped
`timescale 1ns/1ps
module ddi_src (
  // clock
  input  wire logic       i_clk,
  // bench control
  input  wire logic       i_run,
  input  wire logic [3:0] i_half,
  input  wire logic [9:0] i_word,
  // device pins
  output logic            o_wrt,
  output logic            o_clk,
  output logic      [9:0] o_data,
  output logic            o_sel
);
  logic [3:0] cnt_r;
  initial begin
    cnt_r  = 4'h0;
    o_wrt  = 1'b0;
    o_data = 10'h000;
    o_sel  = 1'b1;
  end
  // tied pins give equal periods and clock-with-write order for free
  assign o_clk = o_wrt;
  always @(posedge i_clk) begin
    if (!o_wrt && !i_run) begin
      // stop only in the low phase, next word is always for channel a
      cnt_r  <= 4'h0;
      o_data <= i_word;
      o_sel  <= 1'b1;
    end else if (cnt_r != i_half - 4'h1) begin
      cnt_r <= cnt_r + 4'h1;
    end else begin
      cnt_r <= 4'h0;
      o_wrt <= !o_wrt; // one word per period bounds the update rate
      if (o_wrt) begin
        o_data <= i_word;
        o_sel  <= !o_sel; // a and b words alternate on bus a
      end
    end
  end
endmodule

// ---- dv/tb.sv ----
// Purpose: self-checking bench for the dual converter input front end
// Assumes: design answers apb with its own wait state; sources are tied pins
// Notes:   expected codes come from the bench's own word history
`timescale 1ns/1ps
module tb;
  import ddi_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        strap = 1'b1;
  logic        pr = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic        prdy;
  logic        perr;
  logic        e;
  logic        div;
  logic        rdy;
  logic [1:0]  run = 2'b00;
  logic [1:0]  wrt_q = 2'b00;
  logic [9:0]  word [2];
  logic [9:0]  code [2];
  logic [9:0]  comp [2];
  logic [10:0] hist [2][$];
  wire  [1:0]  wrt;
  wire  [1:0]  ck;
  wire  [1:0]  sel;
  wire  [9:0]  dat [2];
  bit          on = 1'b0;
  bit          fix = 1'b0;
  int          n_fail = 0;
  int          checks = 0;

  always #5 clk = ~clk;

  ddi_src src_a (.i_clk(clk), .i_run(run[0]), .i_half(4'h6), .i_word(word[0]),
    .o_wrt(wrt[0]), .o_clk(ck[0]), .o_data(dat[0]), .o_sel(sel[0]));
  ddi_src src_b (.i_clk(clk), .i_run(run[1]), .i_half(4'h7), .i_word(word[1]),
    .o_wrt(wrt[1]), .o_clk(ck[1]), .o_data(dat[1]), .o_sel(sel[1]));

  ddi_top dut (.I_CORE_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(prdy),
    .O_PRDATA(prdata), .O_PSLVERR(perr), .I_MODE_STRAP(strap),
    .I_CHAN_A_DATA(dat[0]), .I_CHAN_B_DATA(dat[1]), .I_CHAN_A_WRITE_STROBE(wrt[0]),
    .I_CHAN_B_WRITE_STROBE(wrt[1]), .I_CHAN_A_UPDATE_CLOCK(ck[0]),
    .I_CHAN_B_UPDATE_CLOCK(ck[1]), .I_CHANNEL_SELECT(sel[0]), .I_PAIRING_RESET(pr),
    .O_CHAN_A_CODE(code[0]), .O_CHAN_A_CODE_COMP(comp[0]), .O_CHAN_B_CODE(code[1]),
    .O_CHAN_B_CODE_COMP(comp[1]), .O_DIVIDED_CONVERTER_CLOCK(div),
    .O_CAPTURE_READY(rdy));

  task automatic end_of_test;
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (prdy !== 1'b1 && t < 20);
    if (t >= 20) begin
      n_fail++;
      end_of_test();
    end
    r = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk_pipe(input int c);
    int n;
    n = hist[c].size() - 1;
    if (strap) begin
      if (n >= 4) begin
        chk(code[c], hist[c][n-4][9:0]);
        chk(comp[c], 10'h3ff - hist[c][n-4][9:0]);
      end
    end else if (c == 0) begin
      chk(div, n >= 2 && n[0] == 1'b0);
      if (n >= 8 && hist[0][n][10]) begin
        chk(code[0], hist[0][n-8][9:0]);
        chk(code[1], hist[0][n-7][9:0]);
      end
    end
  endtask

  // records each written word; checks outputs at each strobe fall
  always @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      if (wrt[c] && !wrt_q[c]) begin
        hist[c].push_back({sel[c], dat[c]});
        word[c] <= fix ? (c == 0 ? 10'h2a5 : 10'h15a) : 10'($urandom);
      end
      if (!wrt[c] && wrt_q[c] && on) begin
        chk_pipe(c);
      end
    end
    wrt_q <= wrt;
  end

  initial begin
    void'($urandom(75129));
    word[0] = 10'h3ff;
    word[1] = 10'h200;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r[2:0], 3'b011);
    apb(1'b0, 8'h40, 32'h0);
    chk({e, r[30:0]}, 32'h8000_0000);
    on = 1'b1;
    run <= 2'b11;
    repeat (300) @(posedge clk);
    fix = 1'b1;
    repeat (100) @(posedge clk);
    apb(1'b1, ADDR_CTRL, 32'h1);
    repeat (120) @(posedge clk);
    run <= 2'b00;
    repeat (20) @(posedge clk);
    chk(rdy, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({r[4], r[2:1]}, 3'b110);
    apb(1'b1, ADDR_CTRL, 32'h0);
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, ADDR_CAPTURE, 32'h0);
      chk(r[31], i < 8);
      if (i < 8) chk(r[19:0], {10'h15a, 10'h2a5});
    end
    apb(1'b1, ADDR_CTRL, 32'h4);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({r[4], r[2:1]}, 3'b001);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(r[2:0], 3'b000);
    // mode change needs a reset and then a fresh pairing
    on = 1'b0;
    fix = 1'b0;
    strap <= 1'b0;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    pr <= 1'b1;
    run <= 2'b11;
    repeat (4) @(posedge clk);
    repeat (40) begin
      @(posedge clk);
      chk(div, 1'b0);
    end
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({r[6:5], r[0]}, 3'b000);
    run <= 2'b00;
    repeat (20) @(posedge clk);
    hist[0].delete();
    hist[1].delete();
    pr <= 1'b0;
    on = 1'b1;
    repeat (3) @(posedge clk);
    run <= 2'b11;
    repeat (400) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r[6:5], 2'b10);
    // soft pairing reset through the control register must also hold the divider
    on = 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h2);
    repeat (30) @(posedge clk);
    chk(div, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r[6:5], 2'b00);
    end_of_test();
  end
endmodule

// ---- hdl/ddi_fifo.sv ----
// Purpose: capture buffer with valid/ready on both sides
// Assumes: synchronous active-high reset
// Notes:   full and empty are exact; no write when full, no read when empty
`timescale 1ns/1ps
module ddi_fifo #(
  parameter int unsigned WIDTH = 20,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // fill side
  input  wire logic             i_wr_valid,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_wr_ready,
  // drain side
  output logic                  o_rd_valid,
  output logic      [WIDTH-1:0] o_rd_data,
  input  wire logic             i_rd_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    wp_nxt;
  logic [AW-1:0]    rp_r;
  logic [AW-1:0]    rp_nxt;
  logic [AW:0]      cnt_r;
  logic [AW:0]      cnt_nxt;
  logic             do_wr;
  logic             do_rd;

  assign o_wr_ready = (cnt_r != (AW+1)'(DEPTH));
  assign o_rd_valid = (cnt_r != '0);
  assign o_rd_data  = mem_r[rp_r];
  assign do_wr      = i_wr_valid && o_wr_ready;
  assign do_rd      = i_rd_ready && o_rd_valid;

  always_comb begin
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (do_wr) begin
      wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
    end
    if (do_rd) begin
      rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
    end
    if (do_wr && !do_rd) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (do_rd && !do_wr) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage needs no reset; only entries below the count are ever read
  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem_r[wp_r] <= i_wr_data;
    end
  end
endmodule

// ---- hdl/ddi_pipe.sv ----
// Purpose: converter latch pipeline of one channel
// Assumes: i_adv is a one-cycle pulse per update clock rising edge
// Notes:   depth sets the write-to-output latency in update clocks
`timescale 1ns/1ps
module ddi_pipe
  import ddi_pkg::*;
(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // data path
  input  wire logic              i_adv,
  input  wire logic [CODE_W-1:0] i_code,
  output logic      [CODE_W-1:0] o_code
);
  logic [CODE_W-1:0] st_r   [LAT_STAGES];
  logic [CODE_W-1:0] st_nxt [LAT_STAGES];

  always_comb begin
    for (int i = 0; i < LAT_STAGES; i++) begin
      st_nxt[i] = st_r[i];
    end
    if (i_adv) begin
      st_nxt[0] = i_code;
      for (int i = 1; i < LAT_STAGES; i++) begin
        st_nxt[i] = st_r[i-1];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    for (int i = 0; i < LAT_STAGES; i++) begin
      st_r[i] <= i_rst ? CODE_RST : st_nxt[i];
    end
  end

  assign o_code = st_r[LAT_STAGES-1];
endmodule

// ---- hdl/ddi_pkg.sv ----
// Purpose: shared constants for the dual converter input front end
// Assumes: 100 MHz core clock, APB register access with 32-bit data
// Notes:   offsets are byte addresses; one register per aligned word
package ddi_pkg;
  localparam int unsigned   CODE_W        = 10;
  localparam int unsigned   LAT_STAGES    = 4;
  localparam int unsigned   FIFO_DEPTH    = 8;
  localparam int unsigned   FIFO_W        = 2 * CODE_W;
  localparam logic [9:0]    CODE_MAX      = 10'h3ff;
  localparam logic [9:0]    CODE_RST      = 10'h000;
  // update rate ceiling, converted to core cycles (least time, rounded up)
  localparam int unsigned   CLK_PERIOD_PS   = 10000;
  localparam int unsigned   UPDATE_MAX_MSPS = 275;
  localparam int unsigned   UPDATE_MIN_PS   = (1000000 + UPDATE_MAX_MSPS - 1) / UPDATE_MAX_MSPS;
  localparam int unsigned   UPD_CYC_RAW     = (UPDATE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned   UPDATE_MIN_CYC  = (UPD_CYC_RAW < 1) ? 1 : UPD_CYC_RAW;
  localparam logic [7:0]    GAP_MAX         = 8'hff;
  // register map
  localparam logic [7:0]    ADDR_CTRL     = 8'h00;
  localparam logic [7:0]    ADDR_STATUS   = 8'h04;
  localparam logic [7:0]    ADDR_CODES    = 8'h08;
  localparam logic [7:0]    ADDR_CAPTURE  = 8'h0c;
  localparam int unsigned   CTRL_CAP_EN   = 0;
  localparam int unsigned   CTRL_SOFT_PR  = 1;
  localparam int unsigned   CTRL_CLR_ERR  = 2;
  localparam logic [2:0]    CTRL_RST      = 3'h0;
  localparam int unsigned   CAP_VALID_BIT = 31;
  // mode strap: low selects single-bus interleaved, high selects dual-bus
  localparam logic          MODE_INTERLEAVED = 1'b0;
  typedef enum logic [1:0] {
    PR_HOLD  = 2'b00,
    PR_WAITB = 2'b01,
    PR_RUN   = 2'b10
  } ddi_pair_t;
endpackage

// ---- hdl/ddi_top.sv ----
// Purpose: digital input front end of a dual 10-bit converter
// Assumes: all pins synchronous to the core clock; strobes/clocks oversampled
// Notes:   edges of the external strobes and clocks are found by sampling
`timescale 1ns/1ps
import ddi_pkg::*;

// Summary of operation
// - a written sample reaches the converter output after exactly four update clocks
// - input words are straight binary, highest bus bit is the MSB
// - update rate is at most 275 MSPS; only channel A spacing is checked, and at this core rate the check cannot trip
// - strap low selects interleaved single bus, strap high dual bus
// - dual bus: each channel has own bus, strobe and update clock
// - dual bus: strobe rise loads input latch, channel clock loads converter latch
// - interleaved: words alternate on bus A; bus B is ignored
// - interleaved: the unselected input latch keeps its value
// - interleaved: shared clock divided by two drives the converter latches
// - interleaved: capture on strobe rise, present both words on strobe fall
// - pairing reset high holds the divided clock low
// - pairing reset aligns the divided clock so A and B pair correctly
// - outputs carry code and 1023 minus code over 1024 levels
module ddi_top (
  // clock and reset
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_RESET,
  // apb slave
  input  wire logic              I_PSEL,
  input  wire logic              I_PENABLE,
  input  wire logic              I_PWRITE,
  input  wire logic [7:0]        I_PADDR,
  input  wire logic [31:0]       I_PWDATA,
  output logic                   O_PREADY,
  output logic      [31:0]       O_PRDATA,
  output logic                   O_PSLVERR,
  // converter data pins
  input  wire logic              I_MODE_STRAP,
  input  wire logic [ddi_pkg::CODE_W-1:0] I_CHAN_A_DATA,
  input  wire logic [ddi_pkg::CODE_W-1:0] I_CHAN_B_DATA,
  input  wire logic              I_CHAN_A_WRITE_STROBE,
  input  wire logic              I_CHAN_B_WRITE_STROBE,
  input  wire logic              I_CHAN_A_UPDATE_CLOCK,
  input  wire logic              I_CHAN_B_UPDATE_CLOCK,
  input  wire logic              I_CHANNEL_SELECT,
  input  wire logic              I_PAIRING_RESET,
  // converter side
  output logic      [ddi_pkg::CODE_W-1:0] O_CHAN_A_CODE,
  output logic      [ddi_pkg::CODE_W-1:0] O_CHAN_A_CODE_COMP,
  output logic      [ddi_pkg::CODE_W-1:0] O_CHAN_B_CODE,
  output logic      [ddi_pkg::CODE_W-1:0] O_CHAN_B_CODE_COMP,
  output logic                   O_DIVIDED_CONVERTER_CLOCK,
  output logic                   O_CAPTURE_READY
);
  import ddi_pkg::*;

  // edge detection on sampled pins; in interleaved mode bus A pins are shared
  logic        wra_q_r, wrb_q_r, cka_q_r, ckb_q_r;
  logic        wra_rise, wra_fall, wrb_rise, cka_rise, ckb_rise;
  logic        mode_r;
  logic        ilv;
  logic [9:0]  lat_a_r, lat_a_nxt, lat_b_r, lat_b_nxt;
  logic [9:0]  pres_a_r, pres_a_nxt, pres_b_r, pres_b_nxt;
  ddi_pair_t   pair_r, pair_nxt;
  logic        div_r, div_nxt;
  logic        pr_hold;
  logic        adv_a, adv_b;
  logic [9:0]  pin_a, pin_b;
  logic [2:0]  ctrl_r, ctrl_nxt;
  logic        rate_err_r, rate_err_nxt;
  logic        drop_r, drop_nxt;
  logic [7:0]  gap_r, gap_nxt;
  logic        adv_d_r;
  logic        ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        slverr_r, slverr_nxt;
  logic        fifo_wr_ready, fifo_rd_valid, fifo_pop;
  logic [FIFO_W-1:0] fifo_rd_data;
  logic        apb_done;
  logic        map_hit;

  assign wra_rise = I_CHAN_A_WRITE_STROBE && !wra_q_r;
  assign wra_fall = !I_CHAN_A_WRITE_STROBE && wra_q_r;
  assign wrb_rise = I_CHAN_B_WRITE_STROBE && !wrb_q_r;
  assign cka_rise = I_CHAN_A_UPDATE_CLOCK && !cka_q_r;
  assign ckb_rise = I_CHAN_B_UPDATE_CLOCK && !ckb_q_r;
  assign ilv      = (mode_r == MODE_INTERLEAVED);
  assign pr_hold  = I_PAIRING_RESET || ctrl_r[CTRL_SOFT_PR];

  // input latches: bus bits taken as-is, bit 9 is the MSB, straight binary
  always_comb begin
    lat_a_nxt  = lat_a_r;
    lat_b_nxt  = lat_b_r;
    pres_a_nxt = pres_a_r;
    pres_b_nxt = pres_b_r;
    if (ilv) begin
      if (wra_rise && I_CHANNEL_SELECT) begin
        lat_a_nxt = I_CHAN_A_DATA;
      end else if (wra_rise) begin
        lat_b_nxt = I_CHAN_A_DATA;
      end
      if (wra_fall) begin
        pres_a_nxt = lat_a_r;
        pres_b_nxt = lat_b_r;
      end
    end else begin
      if (wra_rise) begin
        lat_a_nxt = I_CHAN_A_DATA;
      end
      if (wrb_rise) begin
        lat_b_nxt = I_CHAN_B_DATA;
      end
    end
  end

  // divided converter clock and its pairing alignment
  always_comb begin
    pair_nxt = pair_r;
    div_nxt  = div_r;
    if (pr_hold || !ilv) begin
      pair_nxt = PR_HOLD;
      div_nxt  = 1'b0;
    end else begin
      unique case (pair_r)
        PR_HOLD: begin
          pair_nxt = PR_WAITB;
        end
        PR_WAITB: begin
          // only a clock rise after a B capture may start the divider
          if (wra_rise && !I_CHANNEL_SELECT) begin
            pair_nxt = PR_RUN;
          end
        end
        PR_RUN: begin
          if (cka_rise) begin
            div_nxt = !div_r;
          end
        end
        default: begin
          pair_nxt = PR_HOLD;
        end
      endcase
    end
  end

  // converter latch advance: own clock per channel, or divided clock rise
  assign adv_a = ilv ? (div_nxt && !div_r) : cka_rise;
  assign adv_b = ilv ? (div_nxt && !div_r) : ckb_rise;
  assign pin_a = ilv ? pres_a_r : lat_a_r;
  assign pin_b = ilv ? pres_b_r : lat_b_r;

  ddi_pipe u_pipe_a (
    .i_clk  (I_CORE_CLK),
    .i_rst  (I_RESET),
    .i_adv  (adv_a),
    .i_code (pin_a),
    .o_code (O_CHAN_A_CODE)
  );

  ddi_pipe u_pipe_b (
    .i_clk  (I_CORE_CLK),
    .i_rst  (I_RESET),
    .i_adv  (adv_b),
    .i_code (pin_b),
    .o_code (O_CHAN_B_CODE)
  );

  // complementary output carries the steered remainder
  assign O_CHAN_A_CODE_COMP        = CODE_MAX - O_CHAN_A_CODE;
  assign O_CHAN_B_CODE_COMP        = CODE_MAX - O_CHAN_B_CODE;
  assign O_DIVIDED_CONVERTER_CLOCK = div_r;

  // update spacing check; at this core rate it cannot trip, kept for faster clocks
  always_comb begin
    gap_nxt      = (gap_r == GAP_MAX) ? gap_r : gap_r + 1'b1;
    rate_err_nxt = rate_err_r;
    drop_nxt     = drop_r;
    if (apb_done && I_PWRITE && I_PADDR == ADDR_CTRL && I_PWDATA[CTRL_CLR_ERR]) begin
      rate_err_nxt = 1'b0;
      drop_nxt     = 1'b0;
    end
    if (adv_a) begin
      gap_nxt = '0;
      if (gap_r < 8'(UPDATE_MIN_CYC - 1)) begin
        rate_err_nxt = 1'b1;
      end
    end
    // a dropped capture sets the flag even in the clearing cycle
    if (adv_d_r && ctrl_r[CTRL_CAP_EN] && !fifo_wr_ready) begin
      drop_nxt = 1'b1;
    end
  end

  // capture buffer: one entry per update; when full, new captures are dropped and flagged
  ddi_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk      (I_CORE_CLK),
    .i_rst      (I_RESET),
    .i_wr_valid (adv_d_r && ctrl_r[CTRL_CAP_EN]),
    .i_wr_data  ({O_CHAN_B_CODE, O_CHAN_A_CODE}),
    .o_wr_ready (fifo_wr_ready),
    .o_rd_valid (fifo_rd_valid),
    .o_rd_data  (fifo_rd_data),
    .i_rd_ready (fifo_pop)
  );
  assign O_CAPTURE_READY = fifo_wr_ready;

  // apb slave: one wait state so read data comes from a flip-flop
  assign apb_done  = I_PSEL && I_PENABLE && ack_r;
  assign map_hit   = (I_PADDR == ADDR_CTRL) || (I_PADDR == ADDR_STATUS) ||
                     (I_PADDR == ADDR_CODES) || (I_PADDR == ADDR_CAPTURE);
  assign fifo_pop  = apb_done && !I_PWRITE && (I_PADDR == ADDR_CAPTURE) && fifo_rd_valid;
  assign O_PREADY  = ack_r;
  assign O_PRDATA  = rdata_r;
  assign O_PSLVERR = slverr_r && ack_r;

  always_comb begin
    ack_nxt    = 1'b0;
    rdata_nxt  = rdata_r;
    slverr_nxt = 1'b0;
    ctrl_nxt   = ctrl_r;
    if (I_PSEL && I_PENABLE && !ack_r) begin
      ack_nxt    = 1'b1;
      slverr_nxt = !map_hit;
      rdata_nxt  = 32'h0000_0000;
      if (!I_PWRITE) begin
        unique case (I_PADDR)
          ADDR_CTRL:    rdata_nxt = {29'h0, ctrl_r};
          ADDR_STATUS:  rdata_nxt = {25'h0, pair_r, drop_r, rate_err_r,
                                     !fifo_wr_ready, !fifo_rd_valid, mode_r};
          ADDR_CODES:   rdata_nxt = {6'h0, O_CHAN_B_CODE, 6'h0, O_CHAN_A_CODE};
          ADDR_CAPTURE: rdata_nxt = {fifo_rd_valid, 11'h0, fifo_rd_data};
          default:      rdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    if (apb_done && I_PWRITE && I_PADDR == ADDR_CTRL) begin
      ctrl_nxt = {1'b0, I_PWDATA[CTRL_SOFT_PR], I_PWDATA[CTRL_CAP_EN]};
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      // strap is caught while the synchronous reset is held
      mode_r     <= I_MODE_STRAP;
      wra_q_r    <= 1'b0;
      wrb_q_r    <= 1'b0;
      cka_q_r    <= 1'b0;
      ckb_q_r    <= 1'b0;
      lat_a_r    <= CODE_RST;
      lat_b_r    <= CODE_RST;
      pres_a_r   <= CODE_RST;
      pres_b_r   <= CODE_RST;
      pair_r     <= PR_HOLD;
      div_r      <= 1'b0;
      gap_r      <= GAP_MAX;
      rate_err_r <= 1'b0;
      drop_r     <= 1'b0;
      adv_d_r    <= 1'b0;
      ack_r      <= 1'b0;
      rdata_r    <= 32'h0000_0000;
      slverr_r   <= 1'b0;
      ctrl_r     <= CTRL_RST;
    end else begin
      wra_q_r    <= I_CHAN_A_WRITE_STROBE;
      wrb_q_r    <= I_CHAN_B_WRITE_STROBE;
      cka_q_r    <= I_CHAN_A_UPDATE_CLOCK;
      ckb_q_r    <= I_CHAN_B_UPDATE_CLOCK;
      lat_a_r    <= lat_a_nxt;
      lat_b_r    <= lat_b_nxt;
      pres_a_r   <= pres_a_nxt;
      pres_b_r   <= pres_b_nxt;
      pair_r     <= pair_nxt;
      div_r      <= div_nxt;
      gap_r      <= gap_nxt;
      rate_err_r <= rate_err_nxt;
      drop_r     <= drop_nxt;
      adv_d_r    <= adv_a || adv_b;
      ack_r      <= ack_nxt;
      rdata_r    <= rdata_nxt;
      slverr_r   <= slverr_nxt;
      ctrl_r     <= ctrl_nxt;
    end
  end

  // checks
  property p_out_moves_on_update;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (O_CHAN_A_CODE != $past(O_CHAN_A_CODE)) |-> $past(adv_a);
  endproperty
  a_out_moves_on_update: assert property (p_out_moves_on_update)
    else $error("channel A output changed without an update");

  property p_comp_sum;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (10'(O_CHAN_B_CODE + O_CHAN_B_CODE_COMP) == CODE_MAX);
  endproperty
  a_comp_sum: assert property (p_comp_sum)
    else $error("channel B complementary code wrong");

  property p_hold_low;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      I_PAIRING_RESET |=> !O_DIVIDED_CONVERTER_CLOCK;
  endproperty
  a_hold_low: assert property (p_hold_low)
    else $error("divided clock high during pairing reset");

  property p_sel_a;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (ilv && wra_rise && I_CHANNEL_SELECT) |=>
        (lat_a_r == $past(I_CHAN_A_DATA)) && $stable(lat_b_r);
  endproperty
  a_sel_a: assert property (p_sel_a)
    else $error("select high did not load latch A only");

  property p_sel_b;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (ilv && wra_rise && !I_CHANNEL_SELECT) |=>
        (lat_b_r == $past(I_CHAN_A_DATA)) && $stable(lat_a_r);
  endproperty
  a_sel_b: assert property (p_sel_b)
    else $error("select low did not load latch B from bus A");

  property p_present_on_fall;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (ilv && wra_fall) |=> (pres_a_r == $past(lat_a_r)) && (pres_b_r == $past(lat_b_r));
  endproperty
  a_present_on_fall: assert property (p_present_on_fall)
    else $error("latched words not presented on strobe fall");

  property p_div_from_clock;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      $rose(div_r) |-> $past(cka_rise) && $past(pair_r) == PR_RUN;
  endproperty
  a_div_from_clock: assert property (p_div_from_clock)
    else $error("divided clock rose without a shared clock rise");

  property p_dual_b_own_clock;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (!ilv && O_CHAN_B_CODE != $past(O_CHAN_B_CODE)) |-> $past(ckb_rise);
  endproperty
  a_dual_b_own_clock: assert property (p_dual_b_own_clock)
    else $error("channel B updated without its own clock");

  property p_dual_capture;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (!ilv && wrb_rise) |=> lat_b_r == $past(I_CHAN_B_DATA);
  endproperty
  a_dual_capture: assert property (p_dual_capture)
    else $error("channel B strobe did not capture bus B");
endmodule
